// file: cisd_cfg.svh
/*
 * Field positions, lengths and reset values for the instruction decoder.
 * Assumes the fetch unit hands over 16-bit opcode words, first word first.
 */
`ifndef CISD_CFG_SVH
`define CISD_CFG_SVH

// ----------------------------------------------------------------
// First opcode word layout
// ----------------------------------------------------------------
`define CISD_CLS_HI      15
`define CISD_CLS_LO      11
`define CISD_VAR2_BIT    10
`define CISD_VAR1_BIT    9
`define CISD_LONG_BIT    8
`define CISD_RD_HI       7
`define CISD_RD_LO       4
`define CISD_RS_HI       3
`define CISD_RS_LO       0
`define CISD_CNT_HI      5
`define CISD_CNT_LO      4
`define CISD_TRAP_HI     6
`define CISD_TRAP_LO     0

// ----------------------------------------------------------------
// Lengths in bytes and reset values
// ----------------------------------------------------------------
`define CISD_LEN_SHORT   3'h2
`define CISD_LEN_LONG    3'h4
`define CISD_RST_CNT     3'h0
`define CISD_RST_PAGE    16'h0000
`define CISD_STEP_ONE    2'h1
`define CISD_STEP_TWO    2'h2

`endif

// file: cisd_pkg.sv
/*
 * Types shared by the instruction decoder and its datapath neighbours.
 * Assumes the datapath, stack and system-control logic consume cisd_exec_t.
 */
package cisd_pkg;

    // ------------------------------------------------------------
    // Operation classes (bits 15:11 of the first word)
    // ------------------------------------------------------------
    typedef enum logic [4:0] {
        CLS_ADD     = 5'h00, CLS_ADDC    = 5'h01, CLS_SUB   = 5'h02,
        CLS_SUBC    = 5'h03, CLS_MUL     = 5'h04, CLS_DIV   = 5'h05,
        CLS_CMPD    = 5'h06, CLS_CMPI    = 5'h07, CLS_NORM  = 5'h08,
        CLS_SHIFT   = 5'h09, CLS_SAR     = 5'h0a, CLS_MOVBX = 5'h0b,
        CLS_JBIT    = 5'h0c, CLS_BFLD    = 5'h0d, CLS_BITOP = 5'h0e,
        CLS_PSHCL   = 5'h0f, CLS_CTXSW   = 5'h10, CLS_RET   = 5'h11,
        CLS_TRAP    = 5'h12, CLS_PDOFF   = 5'h13, CLS_PAGE  = 5'h14,
        CLS_PREFIX  = 5'h15, CLS_SEGXFER = 5'h16, CLS_MAC   = 5'h17,
        CLS_NOP     = 5'h18
    } cisd_class_t;

    typedef enum logic [2:0] {
        ALU_NONE = 3'h0, ALU_ADD = 3'h1, ALU_SUB = 3'h2, ALU_CMP = 3'h3,
        ALU_MUL  = 3'h4, ALU_DIV = 3'h5
    } cisd_alu_t;

    typedef enum logic [2:0] {
        SH_NONE = 3'h0, SH_SHL = 3'h1, SH_SHR = 3'h2, SH_ROL = 3'h3,
        SH_ROR  = 3'h4, SH_SAR  = 3'h5
    } cisd_shift_t;

    typedef enum logic [2:0] {
        BO_NONE = 3'h0, BO_MOV = 3'h1, BO_MOVN = 3'h2, BO_AND = 3'h3,
        BO_OR   = 3'h4, BO_XOR = 3'h5, BO_CMP  = 3'h6
    } cisd_bitop_t;

    typedef enum logic [1:0] {
        RET_NONE = 2'h0, RET_NEAR = 2'h1, RET_SEG = 2'h2, RET_IRQ = 2'h3
    } cisd_ret_t;

    typedef enum logic [0:0] {
        ST_FIRST  = 1'b0,
        ST_SECOND = 1'b1
    } cisd_state_t;

    // ------------------------------------------------------------
    // Decoded instruction handed to the datapath
    // ------------------------------------------------------------
    typedef struct packed {
        cisd_class_t cls;
        logic        len4;
        logic [3:0]  rd;
        logic [3:0]  rs;
        logic [15:0] imm;
        cisd_alu_t   alu;
        logic        use_carry;
        logic        byte_mode;
        logic        is_signed;
        logic        long_div;
        logic        ptr_upd;
        logic        ptr_inc;
        logic [1:0]  ptr_step;
        logic        extend;
        logic        ext_zero;
        logic        norm_count;
        cisd_shift_t shift;
        logic        bit_jump;
        logic        jump_if_set;
        logic        bit_modify;
        logic        bfld;
        logic        bfld_high;
        cisd_bitop_t bitop;
        logic        stack_push;
        logic        stack_pop;
        logic        call_abs;
        logic        seg_xfer;
        logic        load_imm;
        cisd_ret_t   ret_kind;
        logic        trap;
        logic [6:0]  trap_no;
        logic        mac;
        logic        nop;
        logic        illegal;
        logic        ext_page;
        logic        ext_reg;
        logic        prefix_a;
    } cisd_exec_t;

endpackage

// file: cisd_decoder.sv
/*
 * Instruction decoder: takes opcode words from the fetch unit, finds the
 * length from the first word, collects the second word of long forms and
 * issues one decoded control word per instruction.
 * Assumes the fetch unit sits on the same clock and holds a word until taken.
 */
`timescale 1ns/1ns
`include "cisd_cfg.svh"

module cisd_decoder (
    // Clock and reset
    input  wire logic               i_core_clk,
    input  wire logic               i_sys_rst,
    // Opcode words from the fetch unit
    input  wire logic               i_fetch_valid,
    input  wire logic [15:0]        i_fetch_word,
    output logic                    o_fetch_ready,
    // Decoded instruction to datapath, stack and system control
    output logic                    o_exec_valid,
    output cisd_pkg::cisd_exec_t    o_exec,
    output logic [15:0]             o_ext_page,
    output logic                    o_irq_block
);

    // --------
    // Length lookup
    // --------
    function automatic logic is_long(input logic [15:0] w);
        logic [4:0] c;
        c = w[`CISD_CLS_HI:`CISD_CLS_LO];
        case (c)
            cisd_pkg::CLS_JBIT, cisd_pkg::CLS_BFLD, cisd_pkg::CLS_BITOP,
            cisd_pkg::CLS_PSHCL, cisd_pkg::CLS_CTXSW, cisd_pkg::CLS_PDOFF,
            cisd_pkg::CLS_SEGXFER, cisd_pkg::CLS_MAC:
                is_long = 1'b1;
            cisd_pkg::CLS_ADD, cisd_pkg::CLS_ADDC, cisd_pkg::CLS_SUB,
            cisd_pkg::CLS_SUBC, cisd_pkg::CLS_CMPD, cisd_pkg::CLS_CMPI,
            cisd_pkg::CLS_MOVBX, cisd_pkg::CLS_PAGE:
                is_long = w[`CISD_LONG_BIT];
            default:
                is_long = 1'b0;
        endcase
    endfunction

    // --------
    // Field decode of a complete instruction
    // --------
    function automatic cisd_pkg::cisd_exec_t decode(input logic [15:0] w0,
                                                     input logic [15:0] w1);
        cisd_pkg::cisd_exec_t d;
        logic                 v2;
        logic                 v1;
        d        = '0;
        v2       = w0[`CISD_VAR2_BIT];
        v1       = w0[`CISD_VAR1_BIT];
        d.cls    = cisd_pkg::cisd_class_t'(w0[`CISD_CLS_HI:`CISD_CLS_LO]);
        d.len4   = is_long(w0);
        d.rd     = w0[`CISD_RD_HI:`CISD_RD_LO];
        d.rs     = w0[`CISD_RS_HI:`CISD_RS_LO];
        d.imm    = d.len4 ? w1 : 16'h0000;
        case (d.cls)
            cisd_pkg::CLS_ADD, cisd_pkg::CLS_ADDC: begin
                d.alu       = cisd_pkg::ALU_ADD;
                d.use_carry = (d.cls == cisd_pkg::CLS_ADDC);
                d.byte_mode = v1;
            end
            cisd_pkg::CLS_SUB, cisd_pkg::CLS_SUBC: begin
                d.alu       = cisd_pkg::ALU_SUB;
                d.use_carry = (d.cls == cisd_pkg::CLS_SUBC);
                d.byte_mode = v1;
            end
            cisd_pkg::CLS_MUL: begin
                d.alu       = cisd_pkg::ALU_MUL;
                d.is_signed = ~v2;
            end
            cisd_pkg::CLS_DIV: begin
                // Bit 9 clear divides the low muldiv word, bit 9 set all 32 bits
                d.alu       = cisd_pkg::ALU_DIV;
                d.is_signed = ~v2;
                d.long_div  = v1;
            end
            cisd_pkg::CLS_CMPD, cisd_pkg::CLS_CMPI: begin
                d.alu       = cisd_pkg::ALU_CMP;
                d.ptr_upd   = 1'b1;
                d.ptr_inc   = (d.cls == cisd_pkg::CLS_CMPI);
                d.ptr_step  = v1 ? `CISD_STEP_TWO : `CISD_STEP_ONE;
            end
            cisd_pkg::CLS_NORM: begin
                d.norm_count = 1'b1;
            end
            cisd_pkg::CLS_SHIFT: begin
                case ({v2, v1})
                    2'h0:    d.shift = cisd_pkg::SH_SHL;
                    2'h1:    d.shift = cisd_pkg::SH_SHR;
                    2'h2:    d.shift = cisd_pkg::SH_ROL;
                    default: d.shift = cisd_pkg::SH_ROR;
                endcase
            end
            cisd_pkg::CLS_SAR: begin
                d.shift = cisd_pkg::SH_SAR;
            end
            cisd_pkg::CLS_MOVBX: begin
                d.extend   = 1'b1;
                d.ext_zero = v1;
            end
            cisd_pkg::CLS_JBIT: begin
                // Set-test may clear the bit, clear-test may set it
                d.bit_jump    = 1'b1;
                d.jump_if_set = ~v2;
                d.bit_modify  = v1;
            end
            cisd_pkg::CLS_BFLD: begin
                d.bfld      = 1'b1;
                d.bfld_high = v1;
            end
            cisd_pkg::CLS_BITOP: begin
                case ({w0[`CISD_LONG_BIT], v2, v1})
                    3'h0:    d.bitop = cisd_pkg::BO_MOV;
                    3'h1:    d.bitop = cisd_pkg::BO_MOVN;
                    3'h2:    d.bitop = cisd_pkg::BO_AND;
                    3'h3:    d.bitop = cisd_pkg::BO_OR;
                    3'h4:    d.bitop = cisd_pkg::BO_XOR;
                    3'h5:    d.bitop = cisd_pkg::BO_CMP;
                    default: d.illegal = 1'b1;
                endcase
            end
            cisd_pkg::CLS_PSHCL: begin
                // Stack logic pushes rd before the call target is taken
                d.stack_push = 1'b1;
                d.call_abs   = 1'b1;
            end
            cisd_pkg::CLS_CTXSW: begin
                d.stack_push = 1'b1;
                d.load_imm   = 1'b1;
            end
            cisd_pkg::CLS_RET: begin
                case ({v2, v1})
                    2'h0: d.ret_kind = cisd_pkg::RET_NEAR;
                    2'h1: begin
                        d.ret_kind  = cisd_pkg::RET_NEAR;
                        d.stack_pop = 1'b1;
                    end
                    2'h2:    d.ret_kind = cisd_pkg::RET_SEG;
                    default: d.ret_kind = cisd_pkg::RET_IRQ;
                endcase
            end
            cisd_pkg::CLS_TRAP: begin
                d.trap    = 1'b1;
                d.trap_no = w0[`CISD_TRAP_HI:`CISD_TRAP_LO];
            end
            cisd_pkg::CLS_PDOFF: begin
                // Power reduction is handled elsewhere; decoded but inert
                d.nop = 1'b1;
            end
            cisd_pkg::CLS_PAGE, cisd_pkg::CLS_PREFIX: begin
                d.nop = 1'b1;
            end
            cisd_pkg::CLS_SEGXFER: begin
                d.seg_xfer = 1'b1;
                d.call_abs = v1;
            end
            cisd_pkg::CLS_MAC: begin
                d.mac = 1'b1;
            end
            cisd_pkg::CLS_NOP: begin
                d.nop = 1'b1;
            end
            default: begin
                d.illegal = 1'b1;
            end
        endcase
        return d;
    endfunction

    // --------
    // Word collection
    // --------
    cisd_pkg::cisd_state_t state;
    logic [15:0]           first_word;
    logic                  take;
    logic                  done;
    logic [15:0]           done_w0;
    logic [15:0]           done_w1;
    cisd_pkg::cisd_exec_t  next_exec;
    logic [4:0]            done_cls;
    logic                  is_prefix;

    assign take    = i_fetch_valid & o_fetch_ready;
    // The second word is only asked for once the first word says so
    assign done    = take & ((state == cisd_pkg::ST_SECOND) | ~is_long(i_fetch_word));
    assign done_w0 = (state == cisd_pkg::ST_SECOND) ? first_word : i_fetch_word;
    assign done_w1 = (state == cisd_pkg::ST_SECOND) ? i_fetch_word : 16'h0000;
    assign done_cls = done_w0[`CISD_CLS_HI:`CISD_CLS_LO];
    assign is_prefix = (done_cls == cisd_pkg::CLS_PAGE) | (done_cls == cisd_pkg::CLS_PREFIX);

    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            state <= cisd_pkg::ST_FIRST;
        end else begin
            case (state)
                cisd_pkg::ST_FIRST: begin
                    if (take && is_long(i_fetch_word)) begin
                        state <= cisd_pkg::ST_SECOND;
                    end
                end
                cisd_pkg::ST_SECOND: begin
                    if (take) begin
                        state <= cisd_pkg::ST_FIRST;
                    end
                end
                default: state <= cisd_pkg::ST_FIRST;
            endcase
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            first_word <= 16'h0000;
        end else if (take && state == cisd_pkg::ST_FIRST) begin
            first_word <= i_fetch_word;
        end
    end

    // No output stall exists, so the decoder is ready for a word every cycle out of reset
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            o_fetch_ready <= 1'b0;
        end else begin
            o_fetch_ready <= 1'b1;
        end
    end

    // --------
    // Extended sequence tracking
    // --------
    logic [2:0] ext_cnt;
    logic       ext_page;
    logic       ext_reg;
    logic       prefix_a;
    logic       last_in_seq;

    assign last_in_seq = done & ~is_prefix & (ext_cnt == 3'h1);

    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            ext_cnt  <= `CISD_RST_CNT;
            ext_page <= 1'b0;
            ext_reg  <= 1'b0;
            prefix_a   <= 1'b0;
        end else if (done && is_prefix) begin
            // Count covers 1 to 4 following instructions
            ext_cnt  <= {1'b0, done_w0[`CISD_CNT_HI:`CISD_CNT_LO]} + 3'h1;
            ext_page <= (done_cls == cisd_pkg::CLS_PAGE);
            ext_reg  <= done_w0[`CISD_VAR1_BIT];
            prefix_a   <= (done_cls == cisd_pkg::CLS_PREFIX) & ~done_w0[`CISD_VAR1_BIT];
        end else if (done && ext_cnt != 3'h0) begin
            ext_cnt <= ext_cnt - 3'h1;
            if (last_in_seq) begin
                ext_page <= 1'b0;
                ext_reg  <= 1'b0;
                prefix_a   <= 1'b0;
            end
        end
    end

    // Page comes from the immediate in the long form, else from rs index
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            o_ext_page <= `CISD_RST_PAGE;
        end else if (done && done_cls == cisd_pkg::CLS_PAGE) begin
            o_ext_page <= (state == cisd_pkg::ST_SECOND) ? done_w1
                        : {12'h000, done_w0[`CISD_RS_HI:`CISD_RS_LO]};
        end
    end

    // Interrupts stay held off while any prefix sequence is open
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            o_irq_block <= 1'b0;
        end else if (done && is_prefix) begin
            o_irq_block <= 1'b1;
        end else if (last_in_seq) begin
            o_irq_block <= 1'b0;
        end
    end

    // --------
    // Issue
    // --------
    always_comb begin
        next_exec          = decode(done_w0, done_w1);
        next_exec.ext_page = ext_page & (ext_cnt != 3'h0) & ~is_prefix;
        next_exec.ext_reg  = ext_reg & (ext_cnt != 3'h0) & ~is_prefix;
        next_exec.prefix_a   = prefix_a & (ext_cnt != 3'h0) & ~is_prefix;
    end

    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            o_exec_valid <= 1'b0;
            o_exec       <= '0;
        end else begin
            o_exec_valid <= done;
            if (done) begin
                o_exec <= next_exec;
            end
        end
    end

endmodule

// file: cisd_dec_monitor.sv
/*
 * Checker for the instruction decoder, bound to its ports.
 * Assumes one clock domain and a synchronous active-high reset.
 */
`timescale 1ns/1ns

module cisd_dec_monitor (
    // Clock and reset
    input  wire logic                 i_core_clk,
    input  wire logic                 i_sys_rst,
    // Fetch side
    input  wire logic                 i_fetch_valid,
    input  wire logic [15:0]          i_fetch_word,
    input  wire logic                 o_fetch_ready,
    // Issue side
    input  wire logic                 o_exec_valid,
    input  wire cisd_pkg::cisd_exec_t o_exec,
    input  wire logic [15:0]          o_ext_page,
    input  wire logic                 o_irq_block
);
    // --------
    // Helper logic
    // --------
    logic       take;
    logic [4:0] wc;
    logic [6:0] trap_w;
    logic       long_w;
    logic       pend;
    assign take   = i_fetch_valid & o_fetch_ready;
    assign wc     = i_fetch_word[15:11];
    assign trap_w = i_fetch_word[6:0];
    assign long_w = (wc inside {5'h0c, 5'h0d, 5'h0e, 5'h0f, 5'h10, 5'h13, 5'h16, 5'h17})
                  | ((wc inside {5'h00, 5'h01, 5'h02, 5'h03, 5'h06, 5'h07, 5'h0b, 5'h14}) & i_fetch_word[8]);
    // Next word taken is a long-form tail
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            pend <= 1'b0;
        end else if (take) begin
            pend <= ~pend & long_w;
        end
    end

    // --------
    // Assertions
    // --------
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_sys_rst);
    sequence s_short;
        take && !pend && !long_w;
    endsequence
    sequence s_long_first;
        take && !pend && long_w;
    endsequence
    sequence s_long_tail;
        take && pend;
    endsequence

    rst_clears_a: assert property ($past(i_sys_rst) |-> !o_exec_valid && !o_irq_block && o_ext_page == 16'h0000)
        else $error("reset clear");
    ready_holds_a: assert property (!i_sys_rst |=> o_fetch_ready)
        else $error("ready low");
    short_issue_a: assert property (s_short |=> o_exec_valid && !o_exec.len4)
        else $error("short issue");
    long_wait_a: assert property (s_long_first |=> !o_exec_valid)
        else $error("early long issue");
    long_issue_a: assert property (s_long_tail |=> o_exec_valid && o_exec.len4 && o_exec.imm == $past(i_fetch_word))
        else $error("long issue");
    issue_cause_a: assert property (o_exec_valid |-> $past(take && (pend || !long_w)))
        else $error("stray issue");
    exec_hold_a: assert property (!o_exec_valid && !$past(i_sys_rst) |-> $stable(o_exec))
        else $error("word moved");
    carry_select_a: assert property (o_exec_valid && o_exec.cls[4:2] == 3'h0 |-> o_exec.use_carry == o_exec.cls[0])
        else $error("carry select");
    trap_number_a: assert property (s_short ##0 wc == 5'h12 |=> o_exec.trap && o_exec.trap_no == $past(trap_w))
        else $error("trap number");
    powerdown_nop_a: assert property (o_exec_valid && o_exec.cls == cisd_pkg::CLS_PDOFF |->
        o_exec.nop && o_exec.len4 && !o_exec.illegal)
        else $error("power-down decode");
    mac_long_a: assert property (o_exec_valid && o_exec.cls == cisd_pkg::CLS_MAC |-> o_exec.len4 && o_exec.mac)
        else $error("accumulate length");
    prefix_a_block_a: assert property (s_short ##0 (wc == 5'h15 && !i_fetch_word[9]) |=> ##[0:1] o_irq_block)
        else $error("prefix_a block");
endmodule

bind cisd_decoder cisd_dec_monitor u_mon (
    .i_core_clk    (i_core_clk),
    .i_sys_rst     (i_sys_rst),
    .i_fetch_valid (i_fetch_valid),
    .i_fetch_word  (i_fetch_word),
    .o_fetch_ready (o_fetch_ready),
    .o_exec_valid  (o_exec_valid),
    .o_exec        (o_exec),
    .o_ext_page    (o_ext_page),
    .o_irq_block   (o_irq_block)
);

// file: cisd_fetch_model.sv
/*
 * Behavioural fetch unit: offers queued opcode words, optionally with gaps.
 * Assumes the decoder takes a word on a rising edge with valid and ready.
 */
`timescale 1ns/1ns

module cisd_fetch_model (
    // Clock and reset
    input  wire logic        i_core_clk,
    input  wire logic        i_sys_rst,
    // Decoder handshake
    input  wire logic        i_ready,
    output logic             o_valid,
    output logic [15:0]      o_word
);
    logic [15:0] q[$];
    logic        took;
    int          gap  = 0;
    int          idle = 0;

    task automatic push(input logic [15:0] w);
        q.push_back(w);
    endtask

    initial begin
        o_valid = 1'b0;
        o_word  = 16'h0000;
    end

    // --------
    // Word is held until the edge that samples ready high
    // --------
    always begin
        @(posedge i_core_clk);
        took = o_valid & i_ready;
        #1;
        if (i_sys_rst) begin
            o_valid = 1'b0;
            idle    = 0;
        end else if (took || !o_valid) begin
            if (took) begin
                idle = gap;
            end
            if (idle == 0 && q.size() > 0) begin
                o_valid = 1'b1;
                o_word  = q.pop_front();
            end else begin
                if (idle > 0) begin
                    idle--;
                end
                o_valid = 1'b0;
                // Idle data moves so stale words stand out
                o_word  = ~o_word;
            end
        end
    end
endmodule

// file: tb_top.sv
/*
 * Self-checking bench for the instruction decoder.
 * Assumes the fetch model in its own file and the bound checker.
 */
`timescale 1ns/1ns

module tb_top;
    logic                 i_core_clk;
    logic                 i_sys_rst;
    logic                 fv;
    logic                 rdy;
    logic                 ev;
    logic                 irqb;
    logic [15:0]          fw;
    logic [15:0]          pg;
    cisd_pkg::cisd_exec_t ex;
    cisd_pkg::cisd_exec_t e;
    cisd_pkg::cisd_exec_t got[$];
    int                   err_count = 0;
    int                   tests_run = 0;
    int                   cyc       = 0;

    initial begin
        i_core_clk = 1'b0;
        forever #5 i_core_clk = ~i_core_clk;
    end

    cisd_decoder dut (.i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst), .i_fetch_valid(fv), .i_fetch_word(fw),
        .o_fetch_ready(rdy), .o_exec_valid(ev), .o_exec(ex), .o_ext_page(pg), .o_irq_block(irqb));
    cisd_fetch_model u_fetch (.i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst), .i_ready(rdy), .o_valid(fv),
        .o_word(fw));

    // --------
    // Shared helpers
    // --------
    function automatic logic [15:0] op(input logic [4:0] c, input logic [2:0] v, input logic [7:0] lo);
        return {c, v, lo};
    endfunction

    task automatic final_report();
        $display("counts: comparisons %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    always @(posedge i_core_clk) begin
        cyc++;
        if (ev === 1'b1) begin
            got.push_back(ex);
        end
        if (cyc > 4000) begin
            err_count++;
            final_report();
        end
    end

    task automatic check(input logic [31:0] s, input logic [31:0] x);
        tests_run++;
        if (s !== x) begin
            err_count++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, s, x);
        end
    endtask

    task automatic get(output cisd_pkg::cisd_exec_t e);
        int n = 0;
        while (got.size() == 0 && n < 100) begin
            @(posedge i_core_clk);
            n++;
        end
        e = '0;
        if (got.size() == 0) begin
            err_count++;
        end else begin
            e = got.pop_front();
        end
    endtask

    task automatic dec(input logic [15:0] w1, input logic [15:0] w2 = 16'h0000, input bit lg = 0);
        u_fetch.push(w1);
        if (lg) begin
            u_fetch.push(w2);
        end
        get(e);
    endtask

    // --------
    // Scenarios
    // --------
    task automatic t_arith();
        for (int c = 0; c < 4; c++) begin
            u_fetch.push(op(c[4:0], {2'b00, c[0]}, 8'h12));
            if (c[0]) u_fetch.push(16'ha5c0 + c[15:0]);
        end
        for (int c = 0; c < 4; c++) begin
            get(e);
            check(e.cls, c);
            check(e.len4, c[0]);
            check(e.use_carry, c[0]);
            check(e.alu, c[1] ? cisd_pkg::ALU_SUB : cisd_pkg::ALU_ADD);
            if (c[0]) check(e.imm, 16'ha5c0 + c[15:0]);
        end
        $display("test arith done");
    endtask

    task automatic t_muldiv();
        for (int i = 0; i < 4; i++) u_fetch.push(op(i < 2 ? 5'h04 : 5'h05, {i == 1, i == 3, 1'b0}, 8'h34));
        for (int i = 0; i < 4; i++) begin
            get(e);
            check(e.is_signed, i != 1);
            check(e.long_div, i == 3);
            check(e.alu, i < 2 ? cisd_pkg::ALU_MUL : cisd_pkg::ALU_DIV);
            check(e.len4, 0);
        end
        for (int i = 0; i < 4; i++) begin
            u_fetch.push(op(i[1] ? 5'h07 : 5'h06, {1'b0, i[0], i[1]}, 8'h56));
            if (i[1]) u_fetch.push(16'h0f00);
        end
        for (int i = 0; i < 4; i++) begin
            get(e);
            check({e.ptr_upd, e.ptr_inc, e.alu}, {1'b1, i[1], cisd_pkg::ALU_CMP});
            check(e.len4, i[1]);
            check(e.ptr_step, i[0] ? 2'h2 : 2'h1);
        end
        $display("test muldiv and compare done");
    endtask

    task automatic t_shift();
        // Long bit on a fixed short class is ignored
        for (int i = 0; i < 4; i++) begin
            dec(op(5'h09, {i[1], i[0], 1'b1}, 8'h78));
            check(e.shift, i + 1);
            check(e.len4, 0);
        end
        dec(op(5'h0a, 3'b000, 8'h9a));
        check(e.shift, cisd_pkg::SH_SAR);
        dec(op(5'h08, 3'b000, 8'hbc));
        check({e.norm_count, e.rd, e.rs}, 9'h1bc);
        for (int i = 0; i < 2; i++) begin
            dec(op(5'h0b, {1'b0, i[0], i[0]}, 8'h11), 16'h4321, i[0]);
            check({e.extend, e.ext_zero, e.len4}, {1'b1, i[0], i[0]});
        end
        $display("test shift and move done");
    endtask

    task automatic t_bits();
        for (int i = 0; i < 4; i++) begin
            dec(op(5'h0c, {i[1], i[0], 1'b0}, 8'h22), 16'h0f0f, 1);
            check({e.bit_jump, e.jump_if_set, e.bit_modify, e.len4}, {1'b1, !i[1], i[0], 1'b1});
        end
        for (int i = 0; i < 2; i++) begin
            dec(op(5'h0d, {1'b0, i[0], 1'b0}, 8'h33), 16'hf00f, 1);
            check({e.bfld, e.bfld_high, e.len4}, {1'b1, i[0], 1'b1});
        end
        for (int c = 0; c < 8; c++) begin
            dec(op(5'h0e, c[2:0], 8'h44), 16'h1234, 1);
            check({e.illegal, e.len4}, {c[0] & c[2], 1'b1});
        end
        dec(op(5'h1f, 3'b001, 8'h55));
        check({e.illegal, e.len4}, 2'b10);
        $display("test bit operations done");
    endtask

    task automatic t_flow();
        dec(op(5'h0f, 3'b000, 8'h60), 16'h2000, 1);
        check({e.stack_push, e.call_abs, e.len4}, 3'b111);
        dec(op(5'h10, 3'b000, 8'h70), 16'hbeef, 1);
        check({e.stack_push, e.load_imm, e.len4, e.imm}, {3'b111, 16'hbeef});
        for (int i = 0; i < 4; i++) begin
            dec(op(5'h11, {i[1], i[0], 1'b0}, 8'h80));
            check(e.ret_kind, i[1] ? (i[0] ? cisd_pkg::RET_IRQ : cisd_pkg::RET_SEG) : cisd_pkg::RET_NEAR);
            check({e.stack_pop, e.len4}, {i == 1, 1'b0});
        end
        dec(op(5'h12, 3'b000, 8'h5b));
        check({e.trap, e.trap_no, e.len4}, {1'b1, 7'h5b, 1'b0});
        dec(op(5'h16, 3'b010, 8'h00), 16'h8000, 1);
        check({e.seg_xfer, e.len4, e.imm}, {2'b11, 16'h8000});
        dec(op(5'h17, 3'b000, 8'h00), 16'h0101, 1);
        check({e.mac, e.len4}, 2'b11);
        $display("test control flow done");
    endtask

    task automatic t_prefix();
        // Slow fetch: gaps between words
        u_fetch.gap = 2;
        dec(op(5'h13, 3'b000, 8'h00), 16'h0000, 1);
        check({e.nop, e.len4, e.illegal}, 3'b110);
        dec(op(5'h15, 3'b000, 8'h10));
        check({e.nop, e.len4}, 2'b10);
        for (int i = 0; i < 3; i++) begin
            dec(op(5'h00, 3'b000, 8'h01));
            check(e.prefix_a, i < 2);
        end
        dec(op(5'h14, 3'b001, 8'h00), 16'h3c5a, 1);
        dec(op(5'h00, 3'b000, 8'h01));
        check({e.ext_page, pg}, {1'b1, 16'h3c5a});
        dec(op(5'h14, 3'b000, 8'h07));
        dec(op(5'h02, 3'b000, 8'h01));
        check({e.ext_page, pg}, {1'b1, 16'h0007});
        u_fetch.gap = 0;
        $display("test prefixes done");
    endtask

    // --------
    // Main sequence
    // --------
    initial begin
        i_sys_rst = 1'b1;
        repeat (6) @(posedge i_core_clk);
        #1 i_sys_rst = 1'b0;
        repeat (2) @(posedge i_core_clk);
        t_arith();
        t_muldiv();
        t_shift();
        t_bits();
        t_flow();
        t_prefix();
        final_report();
    end
endmodule
